// ===== dbhp_pkg.sv
// Constants shared by the dual-bus host port and its bench.
// Assumes a single 200 MHz clock and a 32-bit AHB-Lite slave port.
package dbhp_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_PERIOD_PS = 5000;
  localparam int IRQ_RELEASE_US = 2;
  localparam int IRQ_RELEASE_CYC =
    (IRQ_RELEASE_US * 1000000) / CLK_PERIOD_PS;

  // ==========================================================
  // Register byte offsets
  // ==========================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TICKS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // ==========================================================
  // Field layouts and reset values
  // ==========================================================
  localparam int TB_SEL_W = 2;
  localparam logic [1:0] TB_SEL_4M = 2'h0;
  localparam logic [1:0] TB_SEL_1M = 2'h1;
  localparam logic [1:0] TB_SEL_32K = 2'h2;
  localparam logic [1:0] TB_SEL_RST = TB_SEL_4M;
  localparam int ST_MODE_BIT = 0;
  localparam int ST_VRT_BIT = 1;
  localparam int ST_ADDR_LSB = 8;

  // Time-base edges per internal 32.768 kHz tick, minus one
  localparam logic [6:0] TB_LAST_4M = 7'h7f;
  localparam logic [6:0] TB_LAST_1M = 7'h1f;
  localparam logic [6:0] TB_LAST_32K = 7'h00;

  // ==========================================================
  // Interrupt events
  // ==========================================================
  localparam int IRQ_W = 4;
  localparam int EV_ADDR = 0;
  localparam int EV_WRITE = 1;
  localparam int EV_READ = 2;
  localparam int EV_PWR = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // ==========================================================
  // Parallel port
  // ==========================================================
  localparam int PADDR_W = 6;
  localparam int PDATA_W = 8;
  localparam logic [5:0] VRT_ADDR = 6'h0d;
  localparam int VRT_BIT = 7;

endpackage

// ===== dbhp_ram.sv
// Small byte store behind the multiplexed processor port.
// Assumes one clock; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
module dbhp_ram #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ==========================================================
  // Storage
  // ==========================================================
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // ==========================================================
  // Registered read
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // dbhp_ram
`default_nettype wire

// ===== dbhp_host_port.sv
// Dual-bus-style host port with clock output, time-base select,
// valid flag and interrupts, behind an AHB-Lite register slave.
// Assumes all pins synchronous to hclk; the bench resolves wires.
//
// Contract
// - Address strobe fall latches data strobe level
// - Strobe low selects level mode, high pulse
// - Level mode: read is strobe and high
// - Level mode: write is strobe and low
// - Pulse mode: inverted read and write pulses
// - Register selects one of three time bases
// - Clock out is time base over one/four
// - Select high: undivided time base out
// - Select low: time base divided by four
// - Reading valid register sets valid flag
// - Only supply sense low clears flag
// - Interrupt released within two microseconds of reset
// - Chip disabled: no action, bus undriven; bus mode is still latched at address strobe fall
// - Address strobe fall latches six address bits
// - Reset clears all pending interrupts
`timescale 1ns/1ps
`default_nettype none
module dbhp_host_port
  import dbhp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic address_strobe,
  input wire logic data_strobe_pin,
  input wire logic read_write_pin,
  input wire logic chip_enable_n,
  input wire logic reset_pin_n,
  input wire logic [7:0] muxed_addr_data_lines_in,
  output logic [7:0] muxed_addr_data_lines_out,
  output logic muxed_addr_data_lines_oe_n,
  output logic irq_pin_out,
  output logic irq_pin_oe_n,
  input wire logic time_base_input,
  input wire logic clock_out_divide_select,
  output logic clock_out_pin,
  input wire logic supply_sense_input
);

  // ==========================================================
  // Decoding helpers
  // ==========================================================
  function automatic logic [6:0] tb_last(input logic [1:0] sel);
    case (sel)
      TB_SEL_1M: tb_last = TB_LAST_1M;
      TB_SEL_32K: tb_last = TB_LAST_32K;
      default: tb_last = TB_LAST_4M;
    endcase
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  logic as_prev, next_as_prev;
  logic rd_prev, next_rd_prev;
  logic wr_prev, next_wr_prev;
  logic ps_prev, next_ps_prev;
  logic tb_prev, next_tb_prev;
  logic mode_pulse, next_mode_pulse;
  logic [PADDR_W-1:0] addr_lat, next_addr_lat;
  logic [PDATA_W-1:0] wdata_lat, next_wdata_lat;
  logic valid_ram_time_flag, next_vrt;
  logic [1:0] div_cnt, next_div_cnt;
  logic [6:0] pre_cnt, next_pre_cnt;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [TB_SEL_W-1:0] tb_sel, next_tb_sel;
  logic [IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic dp_write, next_dp_write;
  logic [7:0] dp_addr, next_dp_addr;
  logic [31:0] next_hrdata;
  logic [7:0] next_ad_out;
  logic next_ad_oe_n;
  logic next_irq_pin_oe_n;
  logic next_irq;
  logic next_clock_out_pin;

  logic acc_ok, rd_en, wr_en, as_fall, wr_done, rd_start;
  logic tb_rise, tick, ahb_acc, stat_rd;
  logic [IRQ_W-1:0] events;
  logic [PDATA_W-1:0] ram_rdata;

  // ==========================================================
  // Byte store
  // ==========================================================
  dbhp_ram #(
    .AW(PADDR_W),
    .DW(PDATA_W)
  ) u_ram (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(wr_done),
    .waddr(addr_lat),
    .wdata(wdata_lat),
    .raddr(addr_lat),
    .rdata(ram_rdata)
  );

  // ==========================================================
  // Internal enables
  // ==========================================================
  always_comb begin
    // Blocked during strobe and while the part is held in reset
    acc_ok = ~chip_enable_n & reset_pin_n & ~address_strobe &
      ~as_prev;
    if (mode_pulse) begin
      rd_en = acc_ok & ~data_strobe_pin;
      wr_en = acc_ok & ~read_write_pin;
    end else begin
      rd_en = acc_ok & data_strobe_pin & read_write_pin;
      wr_en = acc_ok & data_strobe_pin & ~read_write_pin;
    end
    as_fall = as_prev & ~address_strobe;
    wr_done = wr_prev & ~wr_en;
    rd_start = rd_en & ~rd_prev;
    tb_rise = time_base_input & ~tb_prev;
    tick = tb_rise & (pre_cnt == tb_last(tb_sel));
    ahb_acc = hsel & htrans[1] & hready & (hsize == 3'h2);
    stat_rd = ahb_acc & ~hwrite & (haddr[7:0] == OFS_IRQ_STAT);
    events = '0;
    events[EV_ADDR] = as_fall & ~chip_enable_n & reset_pin_n;
    events[EV_WRITE] = wr_done;
    events[EV_READ] = rd_start;
    events[EV_PWR] = ps_prev & ~supply_sense_input;
  end

  // ==========================================================
  // Parallel port next state
  // ==========================================================
  always_comb begin
    next_as_prev = address_strobe;
    next_rd_prev = rd_en;
    next_wr_prev = wr_en;
    next_ps_prev = supply_sense_input;
    next_mode_pulse = mode_pulse;
    next_addr_lat = addr_lat;
    next_wdata_lat = wdata_lat;
    if (as_fall) begin
      // High strobe level means separate pulse host
      next_mode_pulse = data_strobe_pin;
      if (!chip_enable_n && reset_pin_n) begin
        next_addr_lat = muxed_addr_data_lines_in[PADDR_W-1:0];
      end
    end
    if (wr_en) begin
      next_wdata_lat = muxed_addr_data_lines_in;
    end
    // Set by a read of the valid address beats the clear
    if (rd_start && addr_lat == VRT_ADDR) begin
      next_vrt = 1'b1;
    end else if (!supply_sense_input) begin
      next_vrt = 1'b0;
    end else begin
      next_vrt = valid_ram_time_flag;
    end
    if (addr_lat == VRT_ADDR) begin
      next_ad_out = '0;
      next_ad_out[VRT_BIT] = valid_ram_time_flag;
    end else begin
      next_ad_out = ram_rdata;
    end
    next_ad_oe_n = ~rd_en;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      as_prev <= 1'b0;
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      ps_prev <= 1'b1;
      mode_pulse <= 1'b0;
      addr_lat <= '0;
      wdata_lat <= '0;
      valid_ram_time_flag <= 1'b0;
      muxed_addr_data_lines_out <= '0;
      muxed_addr_data_lines_oe_n <= 1'b1;
    end else begin
      as_prev <= next_as_prev;
      rd_prev <= next_rd_prev;
      wr_prev <= next_wr_prev;
      ps_prev <= next_ps_prev;
      mode_pulse <= next_mode_pulse;
      addr_lat <= next_addr_lat;
      wdata_lat <= next_wdata_lat;
      valid_ram_time_flag <= next_vrt;
      muxed_addr_data_lines_out <= next_ad_out;
      muxed_addr_data_lines_oe_n <= next_ad_oe_n;
    end
  end

  // ==========================================================
  // Time base and clock output
  // ==========================================================
  always_comb begin
    next_tb_prev = time_base_input;
    next_div_cnt = div_cnt;
    next_pre_cnt = pre_cnt;
    next_tick_cnt = tick_cnt;
    if (tb_rise) begin
      next_div_cnt = div_cnt + 2'h1;
      next_pre_cnt = tick ? 7'h00 : pre_cnt + 7'h01;
    end
    if (tick) begin
      next_tick_cnt = tick_cnt + 32'h1;
    end
    if (clock_out_divide_select) begin
      next_clock_out_pin = time_base_input;
    end else begin
      next_clock_out_pin = div_cnt[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb_prev <= 1'b0;
      div_cnt <= '0;
      pre_cnt <= '0;
      tick_cnt <= '0;
      clock_out_pin <= 1'b0;
    end else begin
      tb_prev <= next_tb_prev;
      div_cnt <= next_div_cnt;
      pre_cnt <= next_pre_cnt;
      tick_cnt <= next_tick_cnt;
      clock_out_pin <= next_clock_out_pin;
    end
  end

  // ==========================================================
  // AHB-Lite slave and interrupts
  // ==========================================================
  always_comb begin
    next_dp_write = ahb_acc & hwrite;
    next_dp_addr = ahb_acc ? haddr[7:0] : dp_addr;
    next_tb_sel = tb_sel;
    next_irq_mask = irq_mask;
    if (dp_write) begin
      case (dp_addr)
        OFS_CTRL: next_tb_sel = hwdata[TB_SEL_W-1:0];
        OFS_IRQ_MASK: next_irq_mask = hwdata[IRQ_W-1:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    next_hrdata = hrdata;
    if (ahb_acc && !hwrite) begin
      next_hrdata = '0;
      case (haddr[7:0])
        OFS_CTRL: next_hrdata[TB_SEL_W-1:0] = tb_sel;
        OFS_STATUS: begin
          next_hrdata[ST_MODE_BIT] = mode_pulse;
          next_hrdata[ST_VRT_BIT] = valid_ram_time_flag;
          next_hrdata[ST_ADDR_LSB +: PADDR_W] = addr_lat;
        end
        OFS_TICKS: next_hrdata = tick_cnt;
        OFS_IRQ_STAT: next_hrdata[IRQ_W-1:0] = irq_stat;
        OFS_IRQ_MASK: next_hrdata[IRQ_W-1:0] = irq_mask;
        default: next_hrdata = '0;
      endcase
    end
    // New events win over the read clear
    next_irq_stat = (stat_rd ? '0 : irq_stat) | events;
    if (!reset_pin_n) begin
      next_irq_stat = '0;
      next_irq_mask = IRQ_MASK_RST;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
    next_irq_pin_oe_n = ~next_irq;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= '0;
      tb_sel <= TB_SEL_RST;
      irq_mask <= IRQ_MASK_RST;
      irq_stat <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
      irq_pin_out <= 1'b0;
      irq_pin_oe_n <= 1'b1;
    end else begin
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      tb_sel <= next_tb_sel;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= next_irq;
      irq_pin_out <= 1'b0;
      irq_pin_oe_n <= next_irq_pin_oe_n;
    end
  end

endmodule // dbhp_host_port
`default_nettype wire

// ===== dbhp_host_port_asserts.sv
// Checker for the host port pins and register slave.
// Assumes it is bound to dbhp_host_port by the bind below.
`timescale 1ns/1ps
`default_nettype none
module dbhp_host_port_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq,
  input wire logic address_strobe,
  input wire logic data_strobe_pin,
  input wire logic read_write_pin,
  input wire logic chip_enable_n,
  input wire logic reset_pin_n,
  input wire logic muxed_addr_data_lines_oe_n,
  input wire logic irq_pin_oe_n,
  input wire logic time_base_input,
  input wire logic clock_out_divide_select,
  input wire logic clock_out_pin
);
  logic as_q, mode, rd, rd_acc_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ======
  // Shadow of the bus-mode latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) {as_q, mode} <= 2'h0;
    else begin
      as_q <= address_strobe;
      if (as_q && !address_strobe) mode <= data_strobe_pin;
    end
  end
  assign rd = !chip_enable_n && !address_strobe && reset_pin_n &&
    (mode ? !data_strobe_pin : data_strobe_pin && read_write_pin);
  // Register read taken at the previous edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_acc_q <= 1'b0;
    end else begin
      rd_acc_q <= hsel && htrans[1] && hready && !hwrite;
    end
  end
  // ======
  a_read_drive: assert property (
    rd [*3] |=> !muxed_addr_data_lines_oe_n)
    else $error("bus not driven in read");
  a_read_release: assert property (
    !rd [*2] |=> muxed_addr_data_lines_oe_n)
    else $error("bus driven outside read");
  a_ce_quiet: assert property (
    chip_enable_n |=> muxed_addr_data_lines_oe_n)
    else $error("bus driven while disabled");
  a_strobe_quiet: assert property (
    address_strobe |=> muxed_addr_data_lines_oe_n)
    else $error("bus driven during strobe");
  a_clock_out_pin_undiv: assert property (
    clock_out_divide_select && $past(hresetn) &&
    $past(clock_out_divide_select) |->
    clock_out_pin == $past(time_base_input))
    else $error("clock out not undivided");
  a_irq_release: assert property (
    !reset_pin_n [*2] |=> !irq && irq_pin_oe_n)
    else $error("irq held in reset");
  a_irq_pin: assert property ($rose(irq) |-> ##[0:1] !irq_pin_oe_n)
    else $error("irq pin not pulled");
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or erred");
  a_rdata_hold: assert property (!rd_acc_q |-> $stable(hrdata))
    else $error("read data moved");
  c_pulse_read: cover property (mode && rd [*3]);
  c_level_read: cover property (!mode && rd [*3]);
  c_irq_fall: cover property ($fell(irq));
endmodule // dbhp_host_port_asserts
bind dbhp_host_port dbhp_host_port_asserts u_dbhp_host_port_asserts (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .irq, .address_strobe, .data_strobe_pin, .read_write_pin,
  .chip_enable_n, .reset_pin_n, .muxed_addr_data_lines_oe_n, .irq_pin_oe_n,
  .time_base_input, .clock_out_divide_select, .clock_out_pin);
`default_nettype wire

// ===== dbhp_bus_model.sv
// Model of a multiplexed address/data processor bus controller.
// Assumes the port drives the shared lines while its enable is low.
`timescale 1ns/1ps
`default_nettype none
module dbhp_bus_model (
  input wire logic hclk,
  output logic address_strobe,
  output logic data_strobe_pin,
  output logic read_write_pin,
  output logic chip_enable_n,
  output logic [7:0] muxed_addr_data_lines_in,
  input wire logic [7:0] muxed_addr_data_lines_out,
  input wire logic muxed_addr_data_lines_oe_n
);
  logic drv;
  logic [7:0] val, last;
  initial begin
    {address_strobe, drv, val, last} = 18'h0;
    {data_strobe_pin, read_write_pin, chip_enable_n} = 3'h7;
  end
  // Released lines show a changing pattern
  assign muxed_addr_data_lines_in = !muxed_addr_data_lines_oe_n ?
    muxed_addr_data_lines_out : drv ? val : ~last;
  always @(posedge hclk) last <= muxed_addr_data_lines_in;
  task automatic xfer(input logic pm, input logic ce, input logic wr,
    input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    chip_enable_n <= !ce;
    data_strobe_pin <= pm;
    read_write_pin <= 1'h1;
    drv <= 1'h1;
    val <= {2'h0, a};
    address_strobe <= 1'h1;
    repeat (2) @(posedge hclk);
    address_strobe <= 1'h0;
    @(posedge hclk);
    drv <= 1'h0;
    @(posedge hclk);
    drv <= wr;
    val <= d;
    data_strobe_pin <= pm ? wr : 1'h1;
    read_write_pin <= !wr;
    repeat (4) @(posedge hclk);
    q = muxed_addr_data_lines_in;
    data_strobe_pin <= pm;
    @(posedge hclk);
    {drv, read_write_pin, chip_enable_n} <= 3'h3;
    @(posedge hclk);
  endtask
endmodule // dbhp_bus_model
`default_nettype wire

// ===== dbhp_host_port_tb_top.sv
// Self-checking bench for the host port.
// Assumes the bound checker and the bus model beside the design.
`timescale 1ns/1ps
`default_nettype none
module dbhp_host_port_tb_top
  import dbhp_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, t0;
  logic hreadyout, hresp, irq, irq_pin_out, irq_pin_oe_n, ck_q = 0;
  logic address_strobe, data_strobe_pin, read_write_pin, chip_enable_n;
  logic [7:0] ad_in, ad_out, q, d;
  logic ad_oe_n, clock_out_pin, reset_pin_n = 1, time_base_input = 0;
  logic clock_out_divide_select = 1, supply_sense_input = 1;
  logic [5:0] a;
  int mismatches = 0, n_compared = 0, ck_rises = 0, n, k, c0;
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    ck_q <= clock_out_pin;
    if (clock_out_pin && !ck_q) ck_rises++;
  end
  dbhp_host_port u_dbhp_host_port (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .irq, .address_strobe, .data_strobe_pin,
    .read_write_pin, .chip_enable_n, .reset_pin_n,
    .muxed_addr_data_lines_in(ad_in), .muxed_addr_data_lines_out(ad_out),
    .muxed_addr_data_lines_oe_n(ad_oe_n), .irq_pin_out, .irq_pin_oe_n,
    .time_base_input, .clock_out_divide_select, .clock_out_pin,
    .supply_sense_input);
  dbhp_bus_model u_dbhp_bus_model (.hclk, .address_strobe,
    .data_strobe_pin, .read_write_pin, .chip_enable_n,
    .muxed_addr_data_lines_in(ad_in), .muxed_addr_data_lines_out(ad_out),
    .muxed_addr_data_lines_oe_n(ad_oe_n));
  // ======
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] ad,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    {hsel, htrans} <= 3'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic rreg(input logic [7:0] ad, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] r;
    ahb(1'h0, ad, 32'h0, r);
    check(r & m, e);
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] r;
    ahb(1'h1, ad, wd, r);
  endtask
  task automatic pin(input logic pm, input logic ce, input logic wr,
    input logic [5:0] pa, input logic [7:0] pd);
    u_dbhp_bus_model.xfer(pm, ce, wr, pa, pd, q);
  endtask
  function automatic int per_tick(input int s);
    return s == TB_SEL_32K ? 1 : s == TB_SEL_1M ? 32 : 128;
  endfunction
  // ======
  initial begin
    #400us;
    mismatches++;
    results();
  end
  initial begin
    void'($urandom(32'h79ba));
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rreg(OFS_CTRL, 32'h3, {30'h0, TB_SEL_RST});
    rreg(OFS_STATUS, 32'h2, 32'h0);
    rreg(OFS_IRQ_MASK, 32'hf, {28'h0, IRQ_MASK_RST});
    wreg(8'h14, 32'hffffffff);
    rreg(8'h14, 32'hffffffff, 32'h0);
    for (int s = 2; s >= 0; s--) begin
      n = 1 + $urandom % 2;
      k = 4 * n * per_tick(s);
      wreg(OFS_CTRL, s);
      rreg(OFS_CTRL, 32'h3, s);
      clock_out_divide_select <= 1'($urandom);
      ahb(1'h0, OFS_TICKS, 32'h0, t0);
      c0 = ck_rises;
      repeat (k) begin
        time_base_input <= 1'h1;
        repeat (2) @(posedge hclk);
        time_base_input <= 1'h0;
        repeat (2) @(posedge hclk);
      end
      repeat (8) @(posedge hclk);
      rreg(OFS_TICKS, 32'hffffffff, t0 + 4 * n);
      check(ck_rises - c0,
        clock_out_divide_select ? k : k / 4);
    end
    wreg(OFS_IRQ_MASK, 32'hf);
    for (int m = 0; m < 4; m++) begin
      a = 6'($urandom % 13);
      d = 8'($urandom);
      pin(m[0], 1'h1, 1'h1, a, d);
      rreg(OFS_STATUS, 32'h3f01, {18'h0, a, 7'h0, m[0]});
      rreg(OFS_IRQ_STAT, 32'hf, 32'h3);
      pin(!m[0], 1'h1, 1'h0, a, 8'h0);
      check(q, d);
      check(irq, 1'h1);
      rreg(OFS_IRQ_STAT, 32'hf, 32'h5);
      repeat (2) @(posedge hclk);
      check(irq, 1'h0);
    end
    pin(1'h0, 1'h0, 1'h1, a, ~d);
    pin(1'h1, 1'h1, 1'h0, a, 8'h0);
    check(q, d);
    rreg(OFS_IRQ_STAT, 32'hf, 32'h5);
    wreg(OFS_IRQ_MASK, 32'h0);
    pin(1'h1, 1'h1, 1'h1, a, d);
    check(irq, 1'h0);
    wreg(OFS_IRQ_MASK, 32'hf);
    repeat (2) @(posedge hclk);
    check(irq, 1'h1);
    check(irq_pin_oe_n, 1'h0);
    reset_pin_n <= 1'h0;
    repeat (3) @(posedge hclk);
    check(irq, 1'h0);
    check(irq_pin_oe_n, 1'h1);
    reset_pin_n <= 1'h1;
    rreg(OFS_IRQ_MASK, 32'hf, 32'h0);
    rreg(OFS_IRQ_STAT, 32'hf, 32'h0);
    pin(1'h1, 1'h1, 1'h0, VRT_ADDR, 8'h0);
    pin(1'h0, 1'h1, 1'h0, VRT_ADDR, 8'h0);
    check(q, 8'h80);
    wreg(OFS_STATUS, 32'h0);
    pin(1'h1, 1'h1, 1'h1, VRT_ADDR, 8'h0);
    rreg(OFS_STATUS, 32'h2, 32'h2);
    supply_sense_input <= 1'h0;
    repeat (4) @(posedge hclk);
    supply_sense_input <= 1'h1;
    rreg(OFS_STATUS, 32'h2, 32'h0);
    rreg(OFS_IRQ_STAT, 32'h8, 32'h8);
    results();
  end
endmodule // dbhp_host_port_tb_top
`default_nettype wire
